//--- hw/pcs_consts.svh
`ifndef PCS_CONSTS_SVH
`define PCS_CONSTS_SVH
// clock and times, figures in their own units
`define PCS_CLK_HZ        100000000
`define PCS_RTC_MS        10
`define PCS_SWWD_MS       160
`define PCS_BUSTO_MS      100
`define PCS_HWWD_INT_S    25
`define PCS_HWWD_RST_DS   125
`define PCS_CLKMISS_MS    1
`define PCS_FRMMISS_MS    540
`define PCS_REFRESH_MS    16
`define PCS_BOOT_CLOCKS   5
// register byte offsets
`define PCS_OFF_STATUS    8'h00
`define PCS_OFF_CTRL      8'h04
`define PCS_OFF_LVL_PEND  8'h08
`define PCS_OFF_LVL_MASK  8'h0C
`define PCS_OFF_PIO_PEND  8'h10
`define PCS_OFF_PIO_MASK  8'h14
`define PCS_OFF_SEG_ERR   8'h18
`define PCS_OFF_SEG_IDX   8'h1C
`define PCS_OFF_SEG_DATA  8'h20
// control bits
`define PCS_CTRL_SWKICK   0
`define PCS_CTRL_HWKICK   1
`define PCS_CTRL_SWRST    2
`define PCS_CTRL_DROP     3
`define PCS_CTRL_BANK     4
// translator entry fields
`define PCS_SEG_SIZE_HI   27
`define PCS_SEG_SIZE_LO   18
`define PCS_SEG_PROT_HI   17
`define PCS_SEG_PROT_LO   14
`define PCS_SEG_PRESENT   14
`define PCS_SEG_WPROT     15
`define PCS_SEG_START_HI  13
`define PCS_SEG_START_LO  0
// status latch fields
`define PCS_ST_ACTIVE     16
`define PCS_ST_MSIZE_LO   17
`define PCS_ST_PWRFAIL    19
`define PCS_ST_PARERR     20
`define PCS_ST_CLKFAIL    21
// interrupt levels, then processor reset pulse length in clocks
`define PCS_LVL_NMI       7
`define PCS_LVL_PARITY    6
`define PCS_LVL_SEG       5
`define PCS_LVL_MSG       4
`define PCS_LVL_RTC       3
`define PCS_LVL_SERIAL    2
`define PCS_RST_PULSE     16
`endif

//--- hw/pcs_pkg.sv
package pcs_pkg;
  // translator error type
  typedef enum logic [1:0] {
    PCS_SEG_OK     = 2'h0,
    PCS_SEG_ABSENT = 2'h1,
    PCS_SEG_RANGE  = 2'h2,
    PCS_SEG_PROT   = 2'h3
  } pcs_seg_err_t;
  // external card bus takeover, gray along idle->grant->xfer
  typedef enum logic [1:0] {
    PCS_DMA_IDLE  = 2'b00,
    PCS_DMA_GRANT = 2'b01,
    PCS_DMA_XFER  = 2'b11
  } pcs_dma_st_t;
endpackage

//--- hw/pcs_supervisor.sv
`timescale 1ns/1ps
`include "pcs_consts.svh"
module pcs_supervisor #(
  parameter int unsigned RTC_CYC     = `PCS_RTC_MS * (`PCS_CLK_HZ / 1000),
  parameter int unsigned SWWD_CYC    = `PCS_SWWD_MS * (`PCS_CLK_HZ / 1000),
  parameter int unsigned BUSTO_CYC   = `PCS_BUSTO_MS * (`PCS_CLK_HZ / 1000),
  parameter int unsigned HWINT_CYC   = `PCS_HWWD_INT_S * `PCS_CLK_HZ,
  parameter int unsigned HWRST_CYC   = `PCS_HWWD_RST_DS * (`PCS_CLK_HZ / 10),
  parameter int unsigned CLKMISS_CYC = `PCS_CLKMISS_MS * (`PCS_CLK_HZ / 1000),
  parameter int unsigned FRMMISS_CYC = `PCS_FRMMISS_MS * (`PCS_CLK_HZ / 1000),
  parameter int unsigned REF_ROWS    = 1024,
  parameter int unsigned REF_CYC     = `PCS_REFRESH_MS * (`PCS_CLK_HZ / 1000) / REF_ROWS,
  parameter int unsigned SEG_IDX_W   = 11,
  parameter int unsigned SEG_OFF_W   = 13
) (
  input  wire logic                           hclk,
  input  wire logic                           hresetn,
  input  wire logic                           ce,
  // AHB-Lite slave
  input  wire logic                           hsel,
  input  wire logic [31:0]                    haddr,
  input  wire logic [1:0]                     htrans,
  input  wire logic                           hwrite,
  input  wire logic [2:0]                     hsize,
  input  wire logic [31:0]                    hwdata,
  input  wire logic                           hready,
  output logic                                hreadyout,
  output logic [31:0]                         hrdata,
  output logic                                hresp,
  // processor bus cycle
  input  wire logic                           cycle_start_strobe_n,
  input  wire logic                           boot_mem_sel,
  input  wire logic                           ext_access,
  input  wire logic                           transfer_acknowledge_in,
  output logic [3:0]                          state_count,
  output logic                                transfer_acknowledge,
  output logic                                bus_fault,
  // external DMA master card
  input  wire logic                           dma_master_card_req,
  input  wire logic                           master_addr_strobe_n,
  output logic                                dma_bus_grant,
  // reset and activity
  input  wire logic                           cpu_reset_req,
  input  wire logic                           msg_reset,
  input  wire logic                           force_start,
  input  wire logic                           mate_active,
  output logic                                cpu_reset_n,
  output logic                                unit_active,
  // shelf timing
  input  wire logic                           shelf_clk,
  input  wire logic                           frame_pulse,
  // interrupt sources and level output
  input  wire logic                           break_req,
  input  wire logic                           msg_card_irq,
  input  wire logic                           serial_rx_ready,
  input  wire logic                           serial_tx_ready,
  input  wire logic [7:1]                     pio_in,
  output logic [2:0]                          irq_level,
  // translator
  input  wire logic                           seg_valid,
  input  wire logic                           seg_write,
  input  wire logic [SEG_IDX_W+SEG_OFF_W-1:0] seg_vaddr,
  output logic [SEG_OFF_W+13:0]               seg_paddr,
  // memory
  input  wire logic [1:0]                     mem_size,
  input  wire logic                           power_fail,
  input  wire logic                           dram_wr,
  input  wire logic [31:0]                    dram_wdata,
  input  wire logic                           dram_rd_valid,
  input  wire logic [31:0]                    dram_rdata,
  input  wire logic                           dram_rd_parity,
  input  wire logic [15:0]                    dram_addr,
  output logic                                dram_wr_parity,
  output logic                                refresh_req,
  output logic                                boot_bank
);

  localparam int unsigned SEG_N = 1 << SEG_IDX_W;

  // AHB address phase capture
  logic        wr_pend_q;
  logic [7:0]  wr_addr_q;
  logic        wr_en;
  logic [31:0] ctrl_wr;
  logic        rd_take;

  // register state
  logic [7:2]  lvl_pend_q;
  logic [6:2]  lvl_mask_q;
  logic [7:0]  pio_pend_q;
  logic [7:0]  pio_mask_q;
  logic [7:1]  pio_prev_q;
  logic [SEG_IDX_W-1:0] seg_idx_q;
  logic [27:0] seg_mem [SEG_N];
  pcs_pkg::pcs_seg_err_t seg_err_q;
  logic [31:0] status_q;

  // timers and events
  logic [31:0] rtc_cnt_q, swwd_cnt_q, hwwd_cnt_q, busto_cnt_q;
  logic [31:0] clkmiss_cnt_q, frmmiss_cnt_q, ref_cnt_q;
  logic        shelf_clk_q, frame_q, mate_q, active_prev_q;
  logic        rtc_ev, swwd_ev, hwint_ev, hwrst_ev, clk_fail;
  logic        par_ev, seg_ev, drop_ev, gain_ev, rst_ev;
  logic [4:0]  rst_cnt_q;
  pcs_pkg::pcs_dma_st_t dma_st_q;

  assign wr_en   = wr_pend_q & ce;
  assign ctrl_wr = (wr_en && wr_addr_q == `PCS_OFF_CTRL) ? hwdata : 32'h0000_0000;
  assign rd_take = hsel & hready & htrans[1] & ~hwrite & ce;

  // bus slave: zero wait states, read data registered in the address phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= 32'h0000_0000;
    end
    else if (ce && hready)
    begin
      wr_pend_q <= hsel & htrans[1] & hwrite;
      wr_addr_q <= haddr[7:0];
      hrdata    <= 32'h0000_0000;
      if (rd_take)
      begin
        case (haddr[7:0])
          `PCS_OFF_STATUS:   hrdata <= status_q;
          `PCS_OFF_CTRL:     hrdata <= {27'h0, boot_bank, 4'h0};
          `PCS_OFF_LVL_PEND: hrdata <= {24'h0, lvl_pend_q, 2'h0};
          `PCS_OFF_LVL_MASK: hrdata <= {25'h0, lvl_mask_q, 2'h0};
          `PCS_OFF_PIO_PEND: hrdata <= {24'h0, pio_pend_q};
          `PCS_OFF_PIO_MASK: hrdata <= {24'h0, pio_mask_q};
          `PCS_OFF_SEG_ERR:  hrdata <= {30'h0, seg_err_q};
          `PCS_OFF_SEG_IDX:  hrdata <= {{(32-SEG_IDX_W){1'b0}}, seg_idx_q};
          `PCS_OFF_SEG_DATA: hrdata <= {4'h0, seg_mem[seg_idx_q]};
          default:           hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // software-writable configuration
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      lvl_mask_q <= 5'h00;
      pio_mask_q <= 8'h00;
      seg_idx_q  <= '0;
      boot_bank  <= 1'b0;
    end
    else if (wr_en)
    begin
      case (wr_addr_q)
        `PCS_OFF_LVL_MASK: lvl_mask_q <= hwdata[6:2];
        `PCS_OFF_PIO_MASK: pio_mask_q <= hwdata[7:0];
        `PCS_OFF_SEG_IDX:  seg_idx_q  <= hwdata[SEG_IDX_W-1:0];
        `PCS_OFF_CTRL:     boot_bank  <= hwdata[`PCS_CTRL_BANK];
        default:           seg_idx_q  <= seg_idx_q;
      endcase
    end
  end

  // translator table, no reset: behaves as the card's table RAM
  always_ff @(posedge hclk)
  begin
    if (wr_en && wr_addr_q == `PCS_OFF_SEG_DATA)
      seg_mem[seg_idx_q] <= hwdata[27:0];
  end

  // translator check: size in units of 8 bytes, absent, write protect
  logic [27:0] seg_ent;
  logic [SEG_OFF_W-1:0] seg_off;
  assign seg_ent = seg_mem[seg_vaddr[SEG_IDX_W+SEG_OFF_W-1:SEG_OFF_W]];
  assign seg_off = seg_vaddr[SEG_OFF_W-1:0];
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      seg_err_q <= pcs_pkg::PCS_SEG_OK;
      seg_paddr <= '0;
      seg_ev    <= 1'b0;
    end
    else if (ce)
    begin
      seg_ev <= 1'b0;
      if (seg_valid)
      begin
        seg_paddr <= {seg_ent[`PCS_SEG_START_HI:`PCS_SEG_START_LO], seg_off};
        if (!seg_ent[`PCS_SEG_PRESENT])
        begin
          seg_err_q <= pcs_pkg::PCS_SEG_ABSENT;
          seg_ev    <= 1'b1;
        end
        else if (seg_off[SEG_OFF_W-1:3] > seg_ent[`PCS_SEG_SIZE_HI:`PCS_SEG_SIZE_LO])
        begin
          seg_err_q <= pcs_pkg::PCS_SEG_RANGE;
          seg_ev    <= 1'b1;
        end
        else if (seg_write && seg_ent[`PCS_SEG_WPROT])
        begin
          seg_err_q <= pcs_pkg::PCS_SEG_PROT;
          seg_ev    <= 1'b1;
        end
      end
    end
  end

  // bus cycle state counter, saturating
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      state_count <= 4'h0;
    else if (ce)
    begin
      if (!cycle_start_strobe_n)
        state_count <= 4'h0;
      else if (dma_st_q != pcs_pkg::PCS_DMA_IDLE && !master_addr_strobe_n && state_count == 4'h0)
        state_count <= 4'h1;
      else if (dma_st_q == pcs_pkg::PCS_DMA_GRANT && !master_addr_strobe_n)
        state_count <= 4'h0;
      else if (state_count != 4'hF)
        state_count <= state_count + 4'h1;
    end
  end

  // acknowledge: boot memory at its fifth clock, else pass external acknowledge
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      transfer_acknowledge <= 1'b0;
    else if (ce)
      transfer_acknowledge <= boot_mem_sel
        ? (state_count == 4'(`PCS_BOOT_CLOCKS - 2))
        : transfer_acknowledge_in;
  end

  // external access timeout
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      busto_cnt_q <= 32'h0000_0000;
      bus_fault   <= 1'b0;
    end
    else if (ce)
    begin
      bus_fault <= 1'b0;
      if (!ext_access || transfer_acknowledge_in)
        busto_cnt_q <= 32'h0000_0000;
      else if (busto_cnt_q == BUSTO_CYC - 1)
      begin
        bus_fault   <= 1'b1;
        busto_cnt_q <= 32'h0000_0000;
      end
      else
        busto_cnt_q <= busto_cnt_q + 32'h0000_0001;
    end
  end

  // bus takeover by the external card; state held until its strobe ends, dma_bus_grant just follows the request a clock later
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      dma_st_q <= pcs_pkg::PCS_DMA_IDLE;
    else if (ce)
    begin
      case (dma_st_q)
        pcs_pkg::PCS_DMA_IDLE:
          if (dma_master_card_req) dma_st_q <= pcs_pkg::PCS_DMA_GRANT;
        pcs_pkg::PCS_DMA_GRANT:
          if (!dma_master_card_req) dma_st_q <= pcs_pkg::PCS_DMA_IDLE;
          else if (!master_addr_strobe_n) dma_st_q <= pcs_pkg::PCS_DMA_XFER;
        pcs_pkg::PCS_DMA_XFER:
          if (master_addr_strobe_n) dma_st_q <= pcs_pkg::PCS_DMA_GRANT;
        default: dma_st_q <= pcs_pkg::PCS_DMA_IDLE;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      dma_bus_grant <= 1'b0;
    else if (ce)
      dma_bus_grant <= dma_master_card_req;
  end

  // real time clock tick
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      rtc_cnt_q <= 32'h0000_0000;
    else if (ce)
      rtc_cnt_q <= (rtc_cnt_q == RTC_CYC - 1) ? 32'h0000_0000 : rtc_cnt_q + 32'h0000_0001;
  end
  assign rtc_ev = ce && rtc_cnt_q == RTC_CYC - 1;

  // software watchdog; kick by control write
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      swwd_cnt_q <= 32'h0000_0000;
    else if (ce)
    begin
      if (ctrl_wr[`PCS_CTRL_SWKICK] || swwd_ev)
        swwd_cnt_q <= 32'h0000_0000;
      else
        swwd_cnt_q <= swwd_cnt_q + 32'h0000_0001;
    end
  end
  assign swwd_ev = ce && !ctrl_wr[`PCS_CTRL_SWKICK] && swwd_cnt_q == SWWD_CYC - 1;

  // hardware watchdog: periods fixed, software can only restart it
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hwwd_cnt_q <= 32'h0000_0000;
    else if (ce)
    begin
      if (ctrl_wr[`PCS_CTRL_HWKICK] || hwint_ev)
        hwwd_cnt_q <= 32'h0000_0000;
      else
        hwwd_cnt_q <= hwwd_cnt_q + 32'h0000_0001;
    end
  end
  assign hwint_ev = ce && !ctrl_wr[`PCS_CTRL_HWKICK] && hwwd_cnt_q == HWINT_CYC - 1;
  assign hwrst_ev = ce && !ctrl_wr[`PCS_CTRL_HWKICK] && hwwd_cnt_q == HWRST_CYC - 1;

  // shelf clock and frame supervision; inputs taken as synchronous
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      shelf_clk_q   <= 1'b0;
      frame_q       <= 1'b0;
      clkmiss_cnt_q <= 32'h0000_0000;
      frmmiss_cnt_q <= 32'h0000_0000;
    end
    else if (ce)
    begin
      shelf_clk_q <= shelf_clk;
      frame_q     <= frame_pulse;
      if (shelf_clk != shelf_clk_q)
        clkmiss_cnt_q <= 32'h0000_0000;
      else if (clkmiss_cnt_q != CLKMISS_CYC)
        clkmiss_cnt_q <= clkmiss_cnt_q + 32'h0000_0001;
      if (frame_pulse && !frame_q)
        frmmiss_cnt_q <= 32'h0000_0000;
      else if (frmmiss_cnt_q != FRMMISS_CYC)
        frmmiss_cnt_q <= frmmiss_cnt_q + 32'h0000_0001;
    end
  end
  assign clk_fail = clkmiss_cnt_q == CLKMISS_CYC || frmmiss_cnt_q == FRMMISS_CYC;

  // parity on write and check on read
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      dram_wr_parity <= 1'b0;
    else if (ce && dram_wr)
      dram_wr_parity <= ^dram_wdata;
  end
  assign par_ev = ce && dram_rd_valid && ((^dram_rdata) != dram_rd_parity);

  // refresh request, one row per pulse
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ref_cnt_q   <= 32'h0000_0000;
      refresh_req <= 1'b0;
    end
    else if (ce)
    begin
      refresh_req <= ref_cnt_q == REF_CYC - 1;
      ref_cnt_q   <= (ref_cnt_q == REF_CYC - 1) ? 32'h0000_0000 : ref_cnt_q + 32'h0000_0001;
    end
  end

  // activity: any drop cause wins over a gain in the same cycle
  assign drop_ev = swwd_ev | ctrl_wr[`PCS_CTRL_DROP] | cpu_reset_req | msg_reset
                 | ctrl_wr[`PCS_CTRL_SWRST] | hwrst_ev | (ce & clk_fail);
  assign gain_ev = force_start | (mate_q & ~mate_active);
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      unit_active   <= 1'b0;
      mate_q        <= 1'b0;
      active_prev_q <= 1'b0;
    end
    else if (ce)
    begin
      mate_q        <= mate_active;
      active_prev_q <= unit_active;
      if (drop_ev)
        unit_active <= 1'b0;
      else if (gain_ev)
        unit_active <= 1'b1;
    end
  end

  // processor reset pulse; power up holds it through the first pulse
  assign rst_ev = (unit_active != active_prev_q) | swwd_ev | hwrst_ev | msg_reset
                | ctrl_wr[`PCS_CTRL_SWRST] | cpu_reset_req;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rst_cnt_q   <= 5'(`PCS_RST_PULSE);
      cpu_reset_n <= 1'b0;
    end
    else if (ce)
    begin
      if (rst_ev)
        rst_cnt_q <= 5'(`PCS_RST_PULSE);
      else if (rst_cnt_q != 5'h00)
        rst_cnt_q <= rst_cnt_q - 5'h01;
      cpu_reset_n <= !rst_ev && rst_cnt_q == 5'h00;
    end
  end

  // level pending, set wins over write-one-to-clear
  logic [7:2] lvl_set;
  logic [7:2] lvl_clr;
  always_comb
  begin
    lvl_set                  = '0;
    lvl_set[`PCS_LVL_NMI]    = swwd_ev | hwint_ev | break_req;
    lvl_set[`PCS_LVL_PARITY] = par_ev;
    lvl_set[`PCS_LVL_SEG]    = seg_ev;
    lvl_set[`PCS_LVL_MSG]    = msg_card_irq;
    lvl_set[`PCS_LVL_RTC]    = rtc_ev;
    lvl_set[`PCS_LVL_SERIAL] = serial_rx_ready | serial_tx_ready;
    lvl_clr = (wr_en && wr_addr_q == `PCS_OFF_LVL_PEND) ? hwdata[7:2] : 6'h00;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      lvl_pend_q <= 6'h00;
    else if (ce)
      lvl_pend_q <= (lvl_pend_q & ~lvl_clr) | lvl_set;
  end

  // level 1 port inputs, rising edge sticky; port 0 is activity drop
  logic [7:0] pio_set;
  logic [7:0] pio_clr;
  assign pio_set = {pio_in & ~pio_prev_q, active_prev_q & ~unit_active};
  assign pio_clr = (wr_en && wr_addr_q == `PCS_OFF_PIO_PEND) ? hwdata[7:0] : 8'h00;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pio_pend_q <= 8'h00;
      pio_prev_q <= 7'h00;
    end
    else if (ce)
    begin
      pio_prev_q <= pio_in;
      pio_pend_q <= (pio_pend_q & ~pio_clr) | pio_set;
    end
  end

  // highest active level wins; level 7 ignores the mask
  logic [7:1] lvl_act;
  logic [2:0] lvl_code;
  always_comb
  begin
    lvl_act[7]   = lvl_pend_q[7];
    lvl_act[6:2] = lvl_pend_q[6:2] & lvl_mask_q;
    lvl_act[1]   = |(pio_pend_q & pio_mask_q);
    lvl_code     = 3'h0;
    for (int i = 1; i <= 7; i++)
      if (lvl_act[i]) lvl_code = 3'(i);
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      irq_level <= 3'h0;
    else if (ce)
      irq_level <= lvl_code;
  end

  // status latch: card state high, failing parity address low
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      status_q <= 32'h0000_0000;
    else if (ce)
    begin
      status_q[`PCS_ST_ACTIVE]                  <= unit_active;
      status_q[`PCS_ST_MSIZE_LO+1:`PCS_ST_MSIZE_LO] <= mem_size;
      status_q[`PCS_ST_PWRFAIL]                 <= power_fail;
      status_q[`PCS_ST_PARERR]                  <= lvl_pend_q[`PCS_LVL_PARITY];
      status_q[`PCS_ST_CLKFAIL]                 <= clk_fail;
      if (par_ev)
        status_q[15:0] <= dram_addr;
    end
  end

endmodule

//--- tb/pcs_supervisor_monitor.sv
`timescale 1ns/1ps
module pcs_supervisor_monitor (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        cycle_start_strobe_n,
  input wire logic        master_addr_strobe_n,
  input wire logic        boot_mem_sel,
  input wire logic        transfer_acknowledge_in,
  input wire logic        transfer_acknowledge,
  input wire logic [3:0]  state_count,
  input wire logic        dma_master_card_req,
  input wire logic        dma_bus_grant,
  input wire logic        dram_wr,
  input wire logic [31:0] dram_wdata,
  input wire logic        dram_wr_parity,
  input wire logic        cpu_reset_n,
  input wire logic        bus_fault
);
  // one clock domain, reset gates everything
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  cnt_clear_a: assert property (!cycle_start_strobe_n |=> state_count == 4'h0)
    else $error("state counter not cleared by cycle start");
  dma_clear_a: assert property ($fell(master_addr_strobe_n) && dma_bus_grant |=> state_count == 4'h0)
    else $error("state counter not cleared by card strobe");
  cnt_step_a: assert property (cycle_start_strobe_n && master_addr_strobe_n && state_count != 4'hF
    |=> state_count == $past(state_count) + 4'h1)
    else $error("state counter did not advance");
  boot_ack_a: assert property (boot_mem_sel && state_count == 4'h3 |=> transfer_acknowledge)
    else $error("boot access not acknowledged on fifth clock");
  ack_copy_a: assert property (!(boot_mem_sel && state_count == 4'h3)
    |=> transfer_acknowledge == $past(transfer_acknowledge_in))
    else $error("acknowledge not following its input");
  grant_follow_a: assert property (dma_master_card_req |=> dma_bus_grant)
    else $error("card request not granted");
  parity_gen_a: assert property (dram_wr |=> dram_wr_parity == ^$past(dram_wdata))
    else $error("write parity wrong");
  rst_pulse_a: assert property ($rose(cpu_reset_n) |-> !$past(cpu_reset_n, 8))
    else $error("processor reset too short");
  // main scenarios reached
  boot_ack_c: cover property (boot_mem_sel && transfer_acknowledge);
  fault_c: cover property (bus_fault);
  dma_c: cover property ($fell(master_addr_strobe_n) && dma_bus_grant);
endmodule
bind pcs_supervisor pcs_supervisor_monitor mon (.*);

//--- tb/pcs_cpu_model.sv
`timescale 1ns/1ps
module pcs_cpu_model (
  input wire logic hclk,
  input wire logic dma_bus_grant,
  output logic     cycle_start_strobe_n = 1'b1,
  output logic     boot_mem_sel = 1'b0,
  output logic     ext_access = 1'b0,
  output logic     transfer_acknowledge_in = 1'b0,
  output logic     dma_master_card_req = 1'b0,
  output logic     master_addr_strobe_n = 1'b1
);
  // one processor cycle; dly sets how slow the far device answers
  task automatic cycle(input logic boot, input int dly);
    @(posedge hclk);
    cycle_start_strobe_n <= 1'b0;
    boot_mem_sel <= boot;
    ext_access <= !boot;
    @(posedge hclk);
    cycle_start_strobe_n <= 1'b1;
    repeat (dly) @(posedge hclk);
    transfer_acknowledge_in <= !boot;
    @(posedge hclk);
    boot_mem_sel <= 1'b0;
    ext_access <= 1'b0;
    transfer_acknowledge_in <= 1'b0;
  endtask
  // card strobes only once the bus is granted
  task automatic dma();
    @(posedge hclk);
    dma_master_card_req <= 1'b1;
    while (dma_bus_grant !== 1'b1) @(posedge hclk);
    master_addr_strobe_n <= 1'b0;
    repeat (2) @(posedge hclk);
    master_addr_strobe_n <= 1'b1;
    dma_master_card_req <= 1'b0;
  endtask
endmodule

//--- tb/pcs_supervisor_tb.sv
`timescale 1ns/1ps
module pcs_supervisor_tb;
  typedef struct packed {logic wr; logic [31:0] a, d, m, e;} pcs_row_t;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, dram_wdata = '0, dram_rdata = '0, r;
  logic [1:0]  htrans = '0, mem_size = 2'h2;
  logic [2:0]  hsize = 3'h2, irq_level;
  logic [3:0]  state_count;
  logic [7:1]  pio_in = '0;
  logic [23:0] seg_vaddr = '0;
  logic [26:0] seg_paddr;
  logic [15:0] dram_addr = '0;
  logic hclk = 1'b0, hresetn = 1'b0, ce = 1'b1, hsel = 1'b0, hwrite = 1'b0, hready;
  logic hreadyout, hresp, transfer_acknowledge, bus_fault, dma_bus_grant, cpu_reset_n;
  logic cycle_start_strobe_n, boot_mem_sel, ext_access, transfer_acknowledge_in;
  logic dma_master_card_req, master_addr_strobe_n, unit_active, dram_wr_parity;
  logic refresh_req, boot_bank, cpu_reset_req = 1'b0, msg_reset = 1'b0, force_start = 1'b0;
  logic mate_active = 1'b0, shelf_clk = 1'b0, frame_pulse = 1'b0, clk_on = 1'b1;
  logic break_req = 1'b0, msg_card_irq = 1'b0, serial_rx_ready = 1'b0, serial_tx_ready = 1'b0;
  logic seg_valid = 1'b0, seg_write = 1'b0, power_fail = 1'b0, dram_wr = 1'b0;
  logic dram_rd_valid = 1'b0, dram_rd_parity = 1'b0;
  int num_errors = 0, checks = 0, faults = 0, cyc = 0, refs = 0;
  // first row kicks both watchdogs so the early tests stay clear of them
  pcs_row_t rows [4] = '{'{1'b1, 32'h4, 32'h13, 32'h0, 32'h0},
    '{1'b0, 32'h4, 32'h0, 32'h10, 32'h10}, '{1'b0, 32'h0, 32'h0, 32'hE0000, 32'h40000},
    '{1'b0, 32'h40, 32'h0, 32'hFFFFFFFF, 32'h0}};
  assign hready = hreadyout;
  always #5 hclk = ~hclk;
  // shelf timing and fault counting
  always @(posedge hclk)
  begin
    cyc <= cyc + 1;
    shelf_clk <= clk_on ? ~shelf_clk : shelf_clk;
    frame_pulse <= (cyc % 100) == 0;
    if (bus_fault === 1'b1) faults <= faults + 1;
    if (refresh_req === 1'b1) refs <= refs + 1;
  end
  pcs_supervisor #(.RTC_CYC(100), .SWWD_CYC(200), .BUSTO_CYC(50), .HWRST_CYC(300),
    .HWINT_CYC(600), .CLKMISS_CYC(40), .FRMMISS_CYC(400), .REF_CYC(10)) dut (.*);
  pcs_cpu_model cpu (.*);
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  // single word transfer, address phase then data phase
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    r = hrdata;
    hsel <= 1'b0;
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // watchdog against hangs
  initial
  begin
    repeat (20000) @(posedge hclk);
    num_errors++;
    print_verdict();
  end
  // main sequence
  initial
  begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (20) @(posedge hclk);
    foreach (rows[i])
    begin
      bus(rows[i].wr, rows[i].a, rows[i].d);
      check(r & rows[i].m, rows[i].e);
    end
    check(32'(boot_bank), 32'h1);
    $display("registers done");
    cpu.cycle(1'b1, 6);
    cpu.cycle(1'b0, 5);
    check(32'(faults), 32'h0);
    cpu.cycle(1'b0, 60);
    check(32'(faults), 32'h1);
    cpu.dma();
    dram_wdata <= 32'h7;
    dram_wr <= 1'b1;
    @(posedge hclk);
    dram_wr <= 1'b0;
    @(negedge hclk);
    check(32'(dram_wr_parity), 32'h1);
    $display("bus cycles done");
    @(posedge hclk);
    force_start <= 1'b1;
    @(posedge hclk);
    force_start <= 1'b0;
    repeat (3) @(negedge hclk);
    check(32'(unit_active), 32'h1);
    bus(1'b1, 32'h4, 32'h1B);
    repeat (3) @(negedge hclk);
    check(32'(unit_active), 32'h0);
    check(32'(cpu_reset_n), 32'h0);
    clk_on <= 1'b0;
    repeat (50) @(negedge hclk);
    bus(1'b0, 32'h0, 32'h0);
    check(r & 32'h200000, 32'h200000);
    clk_on <= 1'b1;
    $display("activity done");
    bus(1'b1, 32'hC, 32'h8);
    bus(1'b1, 32'h4, 32'h13);
    repeat (105) @(negedge hclk);
    check(32'(irq_level), 32'h3);
    // all maskable levels off, then let the watchdogs run out
    bus(1'b1, 32'hC, 32'h0);
    bus(1'b1, 32'h4, 32'h13);
    repeat (205) @(negedge hclk);
    check(32'(irq_level), 32'h7);
    repeat (100) @(negedge hclk);
    check(32'(cpu_reset_n), 32'h0);
    check(32'(refs), 32'((cyc - 9) / 10));
    $display("watchdogs done");
    // freeze, lesser sources, translator, parity
    bus(1'b1, 32'h4, 32'h13);
    bus(1'b1, 32'h8, 32'hFC);
    bus(1'b1, 32'h14, 32'h4);
    bus(1'b1, 32'h20, 32'h0);
    ce <= 1'b0;
    bus(1'b1, 32'h14, 32'h0);
    ce <= 1'b1;
    pio_in <= 7'h02;
    repeat (3) @(negedge hclk);
    check(32'(irq_level), 32'h1);
    @(posedge hclk);
    {break_req, msg_card_irq, serial_rx_ready, serial_tx_ready, seg_valid} <= 5'h1F;
    {dram_rd_valid, dram_rd_parity, seg_vaddr, dram_addr} <= {2'h3, 24'h7, 16'hBEEF};
    @(posedge hclk);
    {break_req, msg_card_irq, serial_rx_ready, serial_tx_ready, seg_valid} <= 5'h00;
    dram_rd_valid <= 1'b0;
    bus(1'b0, 32'h8, 32'h0);
    check(r & 32'hF4, 32'hF4);
    check(32'(seg_paddr), 32'h7);
    bus(1'b0, 32'h18, 32'h0);
    check(r, 32'h1);
    bus(1'b0, 32'h0, 32'h0);
    check(r & 32'h10FFFF, 32'h10BEEF);
    // activity events, drop beats gain, then a reset in mid-run
    mate_active <= 1'b1;
    @(posedge hclk);
    {mate_active, msg_reset} <= 2'h1;
    @(posedge hclk);
    {mate_active, msg_reset} <= 2'h2;
    @(negedge hclk);
    check(32'(unit_active), 32'h0);
    @(posedge hclk);
    mate_active <= 1'b0;
    repeat (2) @(negedge hclk);
    check(32'(unit_active), 32'h1);
    @(posedge hclk);
    cpu_reset_req <= 1'b1;
    @(posedge hclk);
    cpu_reset_req <= 1'b0;
    @(negedge hclk);
    check(32'(unit_active), 32'h0);
    @(posedge hclk);
    hresetn <= 1'b0;
    @(posedge hclk);
    hresetn <= 1'b1;
    repeat (20) @(negedge hclk);
    check(32'({boot_bank, cpu_reset_n}), 32'h1);
    $display("events and reset done");
    print_verdict();
  end
endmodule
